// ### rcs_defs.vh
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

`define RCS_PC_W 21
`define RCS_RESET_VEC 21'h000000
`define RCS_HIGH_VEC 21'h000008
`define RCS_LOW_VEC 21'h000018
`define RCS_RESUME_STEP 21'h000002

`define RCS_ADDR_W 3
`define RCS_IDX_RESET_CTRL 3'h0
`define RCS_IDX_STACK_PTR 3'h1
`define RCS_IDX_TOS 3'h2
`define RCS_IDX_CONFIG 3'h3
`define RCS_IDX_WAKE_SRC 3'h4
`define RCS_IDX_LAST_PC 3'h5

`define RCS_BIT_BRNOUT 0
`define RCS_BIT_POR 1
`define RCS_BIT_PWRDN 2
`define RCS_BIT_TMOUT 3
`define RCS_BIT_RSTINSTR 4
`define RCS_BIT_SWBO_EN 6
`define RCS_BIT_STK_UNF 6
`define RCS_BIT_STK_FULL 7
`define RCS_BIT_STKRST_EN 0
`define RCS_BIT_GIE_HIGH 1
`define RCS_BIT_GIE_LOW 2

`define RCS_SP_W 5
`define RCS_BRNOUT_SW_CFG 2'h1

`define RCS_MODE_FULL 2'h0
`define RCS_MODE_RUN 2'h1
`define RCS_MODE_IDLE 2'h2
`define RCS_MODE_SLEEP 2'h3

`define RCS_POR_SETTLE 2'h2
`define RCS_POR_DONE 2'h3

`endif

// ### rcs_reset_cause.v
// Function
// - power-on: pc 0000h, reset-instr/timeout/powerdown set, power-on and stack flags cleared, brownout flag as below.
// - reset instruction: restart at 0000h, clear reset-instr flag, clear stack pointer, other flags unchanged.
// - brown-out: restart 0000h, set reset-instr/timeout/powerdown, clear brownout flag.
// - pin reset in run mode: restart 0000h, set timeout flag only.
// - pin reset in idle or sleep: restart 0000h, set timeout, clear powerdown.
// - watchdog in full power or run mode: reset to 0000h, clear timeout flag.
// - pin reset in full power: restart 0000h, no flag changes.
// - stack overflow with stack reset enabled: reset 0000h, set stack-full flag.
// - stack underflow with stack reset enabled: reset 0000h, set stack-underflow flag.
// - stack underflow with stack reset disabled: set underflow flag, no reset.
// - watchdog in idle or sleep: wake at pc plus 2, clear timeout and powerdown.
// - interrupt ending power-managed mode: resume pc plus 2, clear powerdown flag.
// - interrupt wake with global enable: push pc plus 2, bump pointer, jump to 0008h/0018h.
// - brownout flag reset value 1 on power-on only when software brownout active.
// - data registers without reset stay unknown at power-on, kept through resets.
// - watchdog wake touches only the designated status flags.
// - interrupt wake leaves a wake-source bit set for software.
// - software brownout enable exists only when config field is 01, else reads 0.
`include "rcs_defs.vh"
module rcs_reset_cause #(
  parameter STKRST_EN_RESET = 1'b1,
  parameter SWBO_EN_RESET = 1'b1
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire master_clear_pin_in,
  input wire brownout_detect_in,
  input wire [1:0] brownout_config_field_in,
  input wire reset_instr_in,
  input wire wdt_timeout_in,
  input wire stack_overflow_in,
  input wire stack_underflow_in,
  input wire int_wake_in,
  input wire int_high_priority_in,
  input wire [7:0] int_flags_in,
  input wire [1:0] power_mode_in,
  input wire [`RCS_PC_W-1:0] pc_in,
  input wire [`RCS_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  output wire [`RCS_PC_W-1:0] pc_load_value_out,
  output wire pc_load_out,
  output wire core_reset_out,
  output wire wake_out
);

  localparam [2:0] EV_NONE = 3'h0;
  localparam [2:0] EV_BROWNOUT = 3'h1;
  localparam [2:0] EV_PIN_RST = 3'h2;
  localparam [2:0] EV_WDT = 3'h3;
  localparam [2:0] EV_RESET_INSTR = 3'h4;
  localparam [2:0] EV_STACK_FULL = 3'h5;
  localparam [2:0] EV_STACK_UNF = 3'h6;
  localparam [2:0] EV_INT_WAKE = 3'h7;

  wire [3:0] pin_sync;
  wire pinrst_lvl;
  wire brn_lvl;
  wire [1:0] cfg_lvl;
  reg pinrst_prev_q;
  reg brn_prev_q;
  wire pinrst_evt;
  wire brn_evt;
  wire sw_brn_active;
  wire pm_sleepy;

  reg rstinstr_q, rstinstr_d;
  reg tmout_q, tmout_d;
  reg pwrdn_q, pwrdn_d;
  reg por_q, por_d;
  reg brnout_q, brnout_d;
  reg stk_full_q, stk_full_d;
  reg stk_unf_q, stk_unf_d;
  reg [`RCS_SP_W-1:0] sp_q, sp_d;
  reg [`RCS_PC_W-1:0] tos_q, tos_d;
  reg [7:0] wake_src_q, wake_src_d;
  reg swbo_en_q, swbo_en_d;
  reg stkrst_en_q, stkrst_en_d;
  reg gie_high_q, gie_high_d;
  reg gie_low_q, gie_low_d;
  reg [1:0] por_cnt_q;

  reg [`RCS_PC_W-1:0] pc_val_q, pc_val_d;
  reg pc_load_q, pc_load_d;
  reg core_reset_q, core_reset_d;
  reg wake_q, wake_d;
  reg [2:0] ev;

  reg wait_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire bus_req;
  wire wr_take;
  wire [7:0] wb;

  wire [`RCS_PC_W-1:0] resume_pc;

  rcs_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({brownout_config_field_in, brownout_detect_in, master_clear_pin_in}),
    .sync_out(pin_sync)
  );

  assign pinrst_lvl = pin_sync[0];
  assign brn_lvl = pin_sync[1];
  assign cfg_lvl = pin_sync[3:2];

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pinrst_prev_q <= 1'b0;
      brn_prev_q <= 1'b0;
    end
    else
    begin
      pinrst_prev_q <= pinrst_lvl;
      brn_prev_q <= brn_lvl;
    end
  end

  assign pinrst_evt = pinrst_lvl & ~pinrst_prev_q;
  assign brn_evt = brn_lvl & ~brn_prev_q;
  assign sw_brn_active = (cfg_lvl == `RCS_BRNOUT_SW_CFG) & swbo_en_q;
  assign pm_sleepy = (power_mode_in == `RCS_MODE_IDLE) | (power_mode_in == `RCS_MODE_SLEEP);
  assign resume_pc = pc_in + `RCS_RESUME_STEP;

  // one cause per cycle, fixed priority: brown-out, pin, watchdog, reset instruction, stack full, stack underflow, interrupt wake
  always @*
  begin
    ev = EV_NONE;
    if (brn_evt)
      ev = EV_BROWNOUT;
    else if (pinrst_evt)
      ev = EV_PIN_RST;
    else if (wdt_timeout_in)
      ev = EV_WDT;
    else if (reset_instr_in)
      ev = EV_RESET_INSTR;
    else if (stack_overflow_in)
      ev = EV_STACK_FULL;
    else if (stack_underflow_in)
      ev = EV_STACK_UNF;
    else if (int_wake_in && power_mode_in != `RCS_MODE_FULL && int_flags_in != 8'h00)
      ev = EV_INT_WAKE;
  end

  assign bus_req = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & ~wait_q & avs_byteenable_in[0];
  assign wb = avs_writedata_in[7:0];

  always @*
  begin
    rstinstr_d = rstinstr_q;
    tmout_d = tmout_q;
    pwrdn_d = pwrdn_q;
    por_d = por_q;
    brnout_d = brnout_q;
    stk_full_d = stk_full_q;
    stk_unf_d = stk_unf_q;
    sp_d = sp_q;
    tos_d = tos_q;
    wake_src_d = wake_src_q;
    swbo_en_d = swbo_en_q;
    stkrst_en_d = stkrst_en_q;
    gie_high_d = gie_high_q;
    gie_low_d = gie_low_q;
    pc_val_d = pc_val_q;
    pc_load_d = 1'b0;
    core_reset_d = 1'b0;
    wake_d = 1'b0;

    // software writes first, so a hardware event in the same cycle overrides them
    if (wr_take)
    begin
      case (avs_address_in)
        `RCS_IDX_RESET_CTRL:
        begin
          rstinstr_d = wb[`RCS_BIT_RSTINSTR];
          por_d = wb[`RCS_BIT_POR];
          brnout_d = wb[`RCS_BIT_BRNOUT];
          if (cfg_lvl == `RCS_BRNOUT_SW_CFG)
            swbo_en_d = wb[`RCS_BIT_SWBO_EN];
        end
        `RCS_IDX_STACK_PTR:
        begin
          stk_full_d = wb[`RCS_BIT_STK_FULL];
          stk_unf_d = wb[`RCS_BIT_STK_UNF];
        end
        `RCS_IDX_CONFIG:
        begin
          stkrst_en_d = wb[`RCS_BIT_STKRST_EN];
          gie_high_d = wb[`RCS_BIT_GIE_HIGH];
          gie_low_d = wb[`RCS_BIT_GIE_LOW];
        end
        `RCS_IDX_WAKE_SRC:
          wake_src_d = wake_src_q & ~wb; // write one to clear
        default:
          wake_src_d = wake_src_q;
      endcase
    end

    case (ev)
      EV_BROWNOUT:
      begin
        rstinstr_d = 1'b1;
        tmout_d = 1'b1;
        pwrdn_d = 1'b1;
        brnout_d = 1'b0;
        sp_d = {`RCS_SP_W{1'b0}};
        pc_val_d = `RCS_RESET_VEC;
        pc_load_d = 1'b1;
        core_reset_d = 1'b1;
      end
      EV_PIN_RST:
      begin
        if (power_mode_in == `RCS_MODE_RUN)
          tmout_d = 1'b1;
        else if (pm_sleepy)
        begin
          tmout_d = 1'b1;
          pwrdn_d = 1'b0;
        end
        sp_d = {`RCS_SP_W{1'b0}};
        pc_val_d = `RCS_RESET_VEC;
        pc_load_d = 1'b1;
        core_reset_d = 1'b1;
      end
      EV_WDT:
      begin
        tmout_d = 1'b0;
        pc_load_d = 1'b1;
        if (pm_sleepy)
        begin
          // a wake, not a reset: stack and data stay as they were
          pwrdn_d = 1'b0;
          pc_val_d = resume_pc;
          wake_d = 1'b1;
        end
        else
        begin
          sp_d = {`RCS_SP_W{1'b0}};
          pc_val_d = `RCS_RESET_VEC;
          core_reset_d = 1'b1;
        end
      end
      EV_RESET_INSTR:
      begin
        rstinstr_d = 1'b0;
        sp_d = {`RCS_SP_W{1'b0}};
        pc_val_d = `RCS_RESET_VEC;
        pc_load_d = 1'b1;
        core_reset_d = 1'b1;
      end
      EV_STACK_FULL:
      begin
        stk_full_d = 1'b1;
        if (stkrst_en_q)
        begin
          sp_d = {`RCS_SP_W{1'b0}};
          pc_val_d = `RCS_RESET_VEC;
          pc_load_d = 1'b1;
          core_reset_d = 1'b1;
        end
      end
      EV_STACK_UNF:
      begin
        stk_unf_d = 1'b1;
        if (stkrst_en_q)
        begin
          sp_d = {`RCS_SP_W{1'b0}};
          pc_val_d = `RCS_RESET_VEC;
          pc_load_d = 1'b1;
          core_reset_d = 1'b1;
        end
      end
      EV_INT_WAKE:
      begin
        pwrdn_d = 1'b0;
        wake_src_d = wake_src_d | int_flags_in;
        pc_load_d = 1'b1;
        wake_d = 1'b1;
        if (gie_high_q | gie_low_q)
        begin
          tos_d = resume_pc;
          sp_d = sp_q + {{(`RCS_SP_W-1){1'b0}}, 1'b1};
          pc_val_d = int_high_priority_in ? `RCS_HIGH_VEC : `RCS_LOW_VEC;
        end
        else
          pc_val_d = resume_pc;
      end
      default:
        pc_load_d = 1'b0;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rstinstr_q <= 1'b1;
      tmout_q <= 1'b1;
      pwrdn_q <= 1'b1;
      por_q <= 1'b0;
      brnout_q <= 1'b0;
      stk_full_q <= 1'b0;
      stk_unf_q <= 1'b0;
      sp_q <= {`RCS_SP_W{1'b0}};
      wake_src_q <= 8'h00;
      swbo_en_q <= SWBO_EN_RESET;
      stkrst_en_q <= STKRST_EN_RESET;
      gie_high_q <= 1'b0;
      gie_low_q <= 1'b0;
      pc_val_q <= `RCS_RESET_VEC;
      pc_load_q <= 1'b1;
      core_reset_q <= 1'b1;
      wake_q <= 1'b0;
      por_cnt_q <= 2'h0;
    end
    else
    begin
      rstinstr_q <= rstinstr_d;
      tmout_q <= tmout_d;
      pwrdn_q <= pwrdn_d;
      por_q <= por_d;
      stk_full_q <= stk_full_d;
      stk_unf_q <= stk_unf_d;
      sp_q <= sp_d;
      wake_src_q <= wake_src_d;
      swbo_en_q <= swbo_en_d;
      stkrst_en_q <= stkrst_en_d;
      gie_high_q <= gie_high_d;
      gie_low_q <= gie_low_d;
      pc_val_q <= pc_val_d;
      pc_load_q <= pc_load_d;
      core_reset_q <= core_reset_d;
      wake_q <= wake_d;
      if (por_cnt_q != `RCS_POR_DONE)
        por_cnt_q <= por_cnt_q + 2'h1;
      // the config strap is only trusted once it has crossed the synchroniser
      if (por_cnt_q == `RCS_POR_SETTLE && ev == EV_NONE && !wr_take)
        brnout_q <= sw_brn_active;
      else
        brnout_q <= brnout_d;
    end
  end

  // return address has no reset: unknown after power-up, kept across resets
  always @(posedge ref_clk_in)
  begin
    tos_q <= tos_d;
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    case (avs_address_in)
      `RCS_IDX_RESET_CTRL:
      begin
        rdata_d[`RCS_BIT_BRNOUT] = brnout_q;
        rdata_d[`RCS_BIT_POR] = por_q;
        rdata_d[`RCS_BIT_PWRDN] = pwrdn_q;
        rdata_d[`RCS_BIT_TMOUT] = tmout_q;
        rdata_d[`RCS_BIT_RSTINSTR] = rstinstr_q;
        rdata_d[`RCS_BIT_SWBO_EN] = swbo_en_q & (cfg_lvl == `RCS_BRNOUT_SW_CFG);
      end
      `RCS_IDX_STACK_PTR:
      begin
        rdata_d[`RCS_SP_W-1:0] = sp_q;
        rdata_d[`RCS_BIT_STK_UNF] = stk_unf_q;
        rdata_d[`RCS_BIT_STK_FULL] = stk_full_q;
      end
      `RCS_IDX_TOS:
        rdata_d[`RCS_PC_W-1:0] = tos_q;
      `RCS_IDX_CONFIG:
      begin
        rdata_d[`RCS_BIT_STKRST_EN] = stkrst_en_q;
        rdata_d[`RCS_BIT_GIE_HIGH] = gie_high_q;
        rdata_d[`RCS_BIT_GIE_LOW] = gie_low_q;
      end
      `RCS_IDX_WAKE_SRC:
        rdata_d[7:0] = wake_src_q;
      `RCS_IDX_LAST_PC:
        rdata_d[`RCS_PC_W-1:0] = pc_val_q;
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  // one wait cycle: data is registered while waitrequest is high, released the cycle after
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      if (bus_req && wait_q)
      begin
        wait_q <= 1'b0;
        rdata_q <= rdata_d;
      end
      else
        wait_q <= 1'b1;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign pc_load_value_out = pc_val_q;
  assign pc_load_out = pc_load_q;
  assign core_reset_out = core_reset_q;
  assign wake_out = wake_q;

endmodule

// ### rcs_reset_cause_sva.sv
`include "rcs_defs.vh"
module rcs_reset_cause_sva (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire master_clear_pin_in,
  input wire brownout_detect_in,
  input wire reset_instr_in,
  input wire wdt_timeout_in,
  input wire stack_overflow_in,
  input wire stack_underflow_in,
  input wire int_wake_in,
  input wire int_high_priority_in,
  input wire [7:0] int_flags_in,
  input wire [1:0] power_mode_in,
  input wire [`RCS_PC_W-1:0] pc_in,
  input wire [`RCS_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [`RCS_PC_W-1:0] pc_load_value_out,
  input wire pc_load_out,
  input wire core_reset_out,
  input wire wake_out
);
  // pin events pass a synchronizer, so judge only cycles well clear of pin activity
  logic [2:0] quiet_q;
  wire quiet = quiet_q == 3'h4;
  wire calm = quiet && !wdt_timeout_in && !reset_instr_in && !stack_overflow_in && !stack_underflow_in;
  always @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      quiet_q <= 3'h0;
    else if (master_clear_pin_in || brownout_detect_in)
      quiet_q <= 3'h0;
    else if (!quiet)
      quiet_q <= quiet_q + 3'h1;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_restart;
    core_reset_out && pc_load_out && !wake_out && pc_load_value_out == `RCS_RESET_VEC;
  endsequence
  sequence s_resume;
    wake_out && pc_load_out && !core_reset_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_wdt_low_wake: assert property (
    quiet && wdt_timeout_in && power_mode_in[1] |=>
    s_resume ##0 pc_load_value_out == $past(pc_in) + `RCS_RESUME_STEP) else $error("wdt wake wrong");
  a_wdt_full_reset: assert property (
    quiet && wdt_timeout_in && !power_mode_in[1] |=> s_restart) else $error("wdt reset wrong");
  a_instr_restart: assert property (
    quiet && !wdt_timeout_in && reset_instr_in |=> s_restart) else $error("instr reset wrong");
  a_int_wake_pc: assert property (
    calm && int_wake_in && power_mode_in != 2'h0 && int_flags_in != 8'h0 |=> s_resume ##0
    (pc_load_value_out == $past(pc_in) + `RCS_RESUME_STEP ||
    pc_load_value_out == ($past(int_high_priority_in) ? `RCS_HIGH_VEC : `RCS_LOW_VEC))) else $error("int wake wrong");
  a_int_refused: assert property (
    calm && int_wake_in && (power_mode_in == 2'h0 || int_flags_in == 8'h0) |=>
    !pc_load_out && !wake_out && !core_reset_out) else $error("int wake not refused");
  a_no_event_idle: assert property (
    calm && !int_wake_in |=> !pc_load_out && !wake_out && !core_reset_out) else $error("spurious load");
  a_reset_vector: assert property (
    core_reset_out |-> pc_load_out && pc_load_value_out == `RCS_RESET_VEC) else $error("reset vector wrong");
  a_bus_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> s_ack) else $error("bus answer wrong");
  a_unmapped_zero: assert property (
    avs_read_in && avs_waitrequest_out && avs_address_in[2:1] == 2'h3 |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind rcs_reset_cause rcs_reset_cause_sva u_rcs_reset_cause_sva (.ref_clk_in, .rst_n_in, .master_clear_pin_in,
  .brownout_detect_in, .reset_instr_in, .wdt_timeout_in, .stack_overflow_in, .stack_underflow_in, .int_wake_in,
  .int_high_priority_in, .int_flags_in, .power_mode_in, .pc_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .pc_load_value_out, .pc_load_out, .core_reset_out, .wake_out);

// ### rcs_reset_cause_tb.sv
`include "rcs_defs.vh"
module rcs_reset_cause_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] rc = `RCS_IDX_RESET_CTRL;
  localparam logic [2:0] sk = `RCS_IDX_STACK_PTR;
  localparam logic [2:0] cf = `RCS_IDX_CONFIG;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  logic bod = 1'b0;
  logic hp = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [1:0] cfg = 2'h1;
  logic [1:0] mode = `RCS_MODE_FULL;
  logic [4:0] ev = 5'h0;
  logic [7:0] flags = 8'h0;
  logic [20:0] pc = 21'h0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  wire [31:0] rdq;
  wire [20:0] ldv;
  wire wreq;
  wire ld;
  wire crst;
  wire wk;
  int err_count = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  rcs_reset_cause u_rcs_reset_cause (.ref_clk_in(clk), .rst_n_in(rst_n), .master_clear_pin_in(pin),
    .brownout_detect_in(bod), .brownout_config_field_in(cfg), .reset_instr_in(ev[1]), .wdt_timeout_in(ev[0]),
    .stack_overflow_in(ev[2]), .stack_underflow_in(ev[3]), .int_wake_in(ev[4]), .int_high_priority_in(hp),
    .int_flags_in(flags), .power_mode_in(mode), .pc_in(pc), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdq),
    .avs_waitrequest_out(wreq), .pc_load_value_out(ldv), .pc_load_out(ld), .core_reset_out(crst), .wake_out(wk));
  task end_sim;
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    rdata = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
      chk("bus wait", 32'h0, 32'h1);
  endtask
  task rchk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rdata);
  endtask
  // outputs packed as load, reset, wake, vector; the vector only counts when a load happens
  task fire(input logic [4:0] e, input logic [23:0] x);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 5'h0;
    #1;
    chk("event", {8'h0, x}, {8'h0, ld, crst, wk, ld ? ldv : 21'h0});
    // end on an edge so the caller's next input change lands on one
    @(posedge clk);
  endtask
  task line(input logic b);
    int n;
    n = 0;
    @(posedge clk);
    bod <= b;
    pin <= !b;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (ld !== 1'b1 && n < 8);
    chk("line reset", 32'hc00000, {8'h0, ld, crst, wk, ldv});
    @(posedge clk);
    bod <= 1'b0;
    pin <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(rc, 32'h5d);
    rchk(sk, 32'h0);
    rchk(3'h6, 32'h0);
    bus(1'b1, rc, 32'h12);
    fire(5'h02, 24'hc00000);
    rchk(rc, 32'h0e);
    fire(5'h01, 24'hc00000);
    rchk(rc, 32'h06);
    line(1'b0);
    rchk(rc, 32'h06);
    mode <= `RCS_MODE_RUN;
    line(1'b0);
    rchk(rc, 32'h0e);
    mode <= `RCS_MODE_SLEEP;
    pc <= 21'h123;
    fire(5'h01, 24'ha00125);
    rchk(rc, 32'h02);
    mode <= `RCS_MODE_IDLE;
    line(1'b0);
    rchk(rc, 32'h0a);
    line(1'b1);
    rchk(rc, 32'h1e);
    fire(5'h04, 24'hc00000);
    rchk(sk, 32'h80);
    bus(1'b1, sk, 32'h0);
    bus(1'b1, cf, 32'h0);
    fire(5'h08, 24'h0);
    rchk(sk, 32'h40);
    bus(1'b1, sk, 32'h0);
    bus(1'b1, cf, 32'h3);
    fire(5'h08, 24'hc00000);
    rchk(sk, 32'h40);
    mode <= `RCS_MODE_SLEEP;
    flags <= 8'h04;
    hp <= 1'b1;
    pc <= 21'h200;
    fire(5'h10, 24'ha00008);
    rchk(`RCS_IDX_TOS, 32'h202);
    rchk(sk, 32'h41);
    rchk(`RCS_IDX_WAKE_SRC, 32'h04);
    rchk(rc, 32'h1a);
    hp <= 1'b0;
    fire(5'h10, 24'ha00018);
    bus(1'b1, cf, 32'h1);
    fire(5'h10, 24'ha00202);
    flags <= 8'h0;
    fire(5'h10, 24'h0);
    rchk(`RCS_IDX_LAST_PC, 32'h202);
    cfg <= 2'h0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(rc, 32'h1c);
    rchk(sk, 32'h0);
    rchk(`RCS_IDX_TOS, 32'h202);
    end_sim();
  end
  // the sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule

// ### rcs_sync.v
module rcs_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // meta_q feeds nothing but sync_q
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
